// >>> rtl/adhp_pkg.sv
// Constants shared by the converter host port and configuration block.
// Assumes the block runs on one 40 MHz system clock with all pins sampled.
package adhp_pkg;

    // ************************************************************
    // Configuration register layout
    // ************************************************************
    localparam int CFG_W = 32;
    localparam logic [31:0] CFG_RESET = 32'h000003ff;
    // Bits that stay active in hardware mode: 22..18, 15..13 and 9..0.
    localparam logic [31:0] HW_ACTIVE_MASK = 32'h007ce3ff;
    localparam int UPPER_LSB = 24;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int LOW_W = 24;
    localparam int DAC_LSB = 0;
    localparam int DAC_W = 10;
    localparam int VREF_BIT = 18;
    localparam int FULL_UPD_BIT = 16;
    localparam int SEQ_BIT = 23;

    // ************************************************************
    // Reference output scaling
    // ************************************************************
    localparam int REF_PROD_W = 22;
    localparam logic [21:0] RANGE_LO_MV = 22'h0009c4;
    localparam logic [21:0] RANGE_HI_MV = 22'h000bb8;
    localparam int REF_SHIFT = 10;
    localparam int REF_MV_W = 12;

    // ************************************************************
    // Ports, frames and counters
    // ************************************************************
    localparam int RES_BITS = 16;
    localparam int NUM_RES = 6;
    localparam int SYNC_W = 32;
    localparam int SEL_B = 1;
    localparam int SEL_C = 2;
    localparam int SH_A_W = 96;
    localparam int SH_B_W = 48;
    localparam int SH_C_W = 32;
    localparam int FALL_W = 7;
    localparam logic [6:0] FALL_LAST = 7'h1f;
    localparam logic [6:0] FALL_MAX = 7'h7f;
    localparam logic [1:0] WR_FIRST = 2'h0;
    localparam logic [1:0] WR_SECOND = 2'h1;
    localparam logic [1:0] WR_THIRD = 2'h2;
    localparam logic [3:0] RD_LAST_WORD = 4'h5;
    localparam logic [3:0] RD_LAST_BYTE = 4'hb;

endpackage

// >>> rtl/adhp_sync2.sv
// Two-stage synchroniser for a bundle of pins from outside the clock domain.
// Assumes each bit is an independent level; words must be held stable.
`timescale 1ns/10ps
module adhp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } adhp_sync_t;

    adhp_sync_t st_r;
    adhp_sync_t st_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = d;
        st_nxt.q = st_r.meta;
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.q;
endmodule // adhp_sync2

// >>> rtl/adhp_host_port.sv
// Host port and configuration register of a six-channel sampling converter.
// Assumes results arrive on clk and all host pins are asynchronous.
// Behaviour
// - Reference output equals range times code plus one over 1024.
// - Configuration bit 18 picks the 2.5 V or the 3 V range.
// - Bus width select low gives 16-bit words, high gives 8-bit bytes.
// - In byte-mode reads byte order select picks which byte comes first.
// - Each serial transfer starts on a falling edge of frame sync.
// - Serial results go MSB first, changing on rising serial clock.
// - Narrow results are padded to 16 bits with leading zeros.
// - Serial input bits are captured on falling serial clock edges.
// - Three outputs: each carries its pair, first then second channel.
// - Two outputs: A0 A1 C0 on first, B0 B1 C1 on second.
// - One output: A0 A1 B0 B1 C0 C1 on the first output.
// - Hardware mode keeps only bit groups 22..18, 15..13 and 9..0.
// - Hardware mode with serial port ignores bits 31..24.
// - Software mode: register alone; pair A start drives all unless sequential.
// - First parallel write sets bits 31..24; word mode holds 23..16 pending.
// - Serial access updates all bits only when bit 16 is one.
// - Register changes only in software mode and survives mode switches.
// - Updates apply at write strobe rise or 32nd falling serial clock.
`timescale 1ns/10ps
module adhp_host_port (
    input wire logic clk,
    input wire logic resetn,
    input wire logic port_type_select,
    input wire logic bus_width_select,
    input wire logic byte_order_select,
    input wire logic config_source_select,
    input wire logic chip_select_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic [15:0] db_in,
    output logic [15:0] db_out,
    output logic db_oe,
    input wire logic frame_sync_in,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic [2:0] port_enable,
    output logic serial_out_first,
    output logic serial_out_second,
    output logic serial_out_third,
    input wire logic pair_a_convert_start,
    input wire logic pair_b_convert_start,
    input wire logic pair_c_convert_start,
    input wire logic [adhp_pkg::RES_BITS-1:0] result_a0,
    input wire logic [adhp_pkg::RES_BITS-1:0] result_a1,
    input wire logic [adhp_pkg::RES_BITS-1:0] result_b0,
    input wire logic [adhp_pkg::RES_BITS-1:0] result_b1,
    input wire logic [adhp_pkg::RES_BITS-1:0] result_c0,
    input wire logic [adhp_pkg::RES_BITS-1:0] result_c1,
    output logic [2:0] convert_start_out,
    output logic [31:0] effective_config,
    output logic [31:0] converter_configuration,
    output logic [9:0] reference_dac_code,
    output logic [11:0] reference_output_mv
);
    // ************************************************************
    // State and helpers
    // ************************************************************
    typedef struct packed {
        logic [adhp_pkg::CFG_W-1:0] cfg;
        logic [adhp_pkg::WORD_W-1:0] pend;
        logic [1:0] wr_cnt;
        logic [3:0] rd_idx;
        logic wr_n_d;
        logic rd_n_d;
        logic fs_d;
        logic sclk_d;
        logic in_frame;
        logic [adhp_pkg::FALL_W-1:0] fall_cnt;
        logic [adhp_pkg::CFG_W-1:0] sdi_sh;
        logic [adhp_pkg::SH_A_W-1:0] sh_a;
        logic [adhp_pkg::SH_B_W-1:0] sh_b;
        logic [adhp_pkg::SH_C_W-1:0] sh_c;
        logic [adhp_pkg::WORD_W-1:0] dbo;
        logic [adhp_pkg::REF_MV_W-1:0] ref_mv;
        logic [adhp_pkg::CFG_W-1:0] eff;
        logic [2:0] cvs;
        logic [2:0] live;
    } adhp_state_t;

    adhp_state_t st_r;
    adhp_state_t st_nxt;

    logic [adhp_pkg::SYNC_W-1:0] sync_q;
    logic port_type_s, bus_width_s, byte_order_s, cfg_src_s;
    logic cs_n_s, wr_n_s, rd_n_s, fs_s, sclk_s, sdi_s;
    logic [2:0] sel_s;
    logic [2:0] cvs_s;
    logic [15:0] db_s;
    logic wr_ev, rd_rise, fs_fall, fs_rise, sclk_rise, sclk_fall, ser_upd;
    logic [adhp_pkg::CFG_W-1:0] sdi_word;
    logic [adhp_pkg::WORD_W-1:0] res [adhp_pkg::NUM_RES];
    logic [adhp_pkg::REF_PROD_W-1:0] ref_prod;
    logic [adhp_pkg::WORD_W-1:0] rd_word;

    // Narrow results are widened with zeros above the top bit.
    function automatic logic [15:0] pad(input logic [adhp_pkg::RES_BITS-1:0] r);
        pad = 16'(r);
    endfunction

    // Every host pin passes the synchroniser before any logic sees it.
    adhp_sync2 #(.W(adhp_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({port_type_select, bus_width_select, byte_order_select,
            config_source_select, chip_select_n, write_n, read_n,
            frame_sync_in, serial_clk, serial_in, port_enable,
            pair_c_convert_start, pair_b_convert_start, pair_a_convert_start,
            db_in}),
        .q(sync_q)
    );

    assign {port_type_s, bus_width_s, byte_order_s, cfg_src_s, cs_n_s, wr_n_s,
            rd_n_s, fs_s, sclk_s, sdi_s, sel_s, cvs_s, db_s} = sync_q;

    // Edge events; strobes count only while chip select is low.
    // The synchroniser leaves reset at zero, so strobe edges wait until every stage holds pin levels.
    assign wr_ev = wr_n_s & ~st_r.wr_n_d & ~cs_n_s & ~port_type_s & cfg_src_s
                   & (&st_r.live);
    assign rd_rise = rd_n_s & ~st_r.rd_n_d & ~cs_n_s & ~port_type_s & (&st_r.live);
    assign fs_fall = ~fs_s & st_r.fs_d & port_type_s;
    assign fs_rise = fs_s & ~st_r.fs_d;
    assign sclk_rise = sclk_s & ~st_r.sclk_d;
    assign sclk_fall = ~sclk_s & st_r.sclk_d;
    assign sdi_word = {st_r.sdi_sh[adhp_pkg::CFG_W-2:0], sdi_s};
    // The 32nd falling edge commits the word; hardware mode never writes.
    assign ser_upd = st_r.in_frame & sclk_fall & cfg_src_s
                     & (st_r.fall_cnt == adhp_pkg::FALL_LAST);

    // Result table, padded once for all readers.
    always_comb begin
        res[0] = pad(result_a0);
        res[1] = pad(result_a1);
        res[2] = pad(result_b0);
        res[3] = pad(result_b1);
        res[4] = pad(result_c0);
        res[5] = pad(result_c1);
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_n_d = wr_n_s;
        st_nxt.rd_n_d = rd_n_s;
        st_nxt.fs_d = fs_s;
        st_nxt.sclk_d = sclk_s;
        st_nxt.live = {st_r.live[1:0], 1'b1};
        rd_word = '0;

        // Parallel configuration writes; the upper byte lands at once.
        if (wr_ev) begin
            if (st_r.wr_cnt == adhp_pkg::WR_FIRST) begin
                st_nxt.cfg[adhp_pkg::UPPER_LSB +: adhp_pkg::BYTE_W] =
                    db_s[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W];
                if (!bus_width_s) begin
                    st_nxt.pend[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W] =
                        db_s[adhp_pkg::BYTE_W-1:0];
                end
                st_nxt.wr_cnt = adhp_pkg::WR_SECOND;
            end else if (!bus_width_s) begin
                st_nxt.cfg[adhp_pkg::LOW_W-1:0] =
                    {st_r.pend[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W], db_s};
                st_nxt.wr_cnt = adhp_pkg::WR_FIRST;
            end else if (st_r.wr_cnt == adhp_pkg::WR_SECOND) begin
                st_nxt.pend[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W] =
                    db_s[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W];
                st_nxt.wr_cnt = adhp_pkg::WR_THIRD;
            end else if (st_r.wr_cnt == adhp_pkg::WR_THIRD) begin
                st_nxt.pend[adhp_pkg::BYTE_W-1:0] =
                    db_s[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W];
                st_nxt.wr_cnt = st_r.wr_cnt + 2'h1;
            end else begin
                st_nxt.cfg[adhp_pkg::LOW_W-1:0] =
                    {st_r.pend, db_s[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W]};
                st_nxt.wr_cnt = adhp_pkg::WR_FIRST;
            end
        end

        // Parallel result reads step through the six words or twelve bytes.
        if (rd_rise) begin
            if (st_r.rd_idx == (bus_width_s ? adhp_pkg::RD_LAST_BYTE
                                            : adhp_pkg::RD_LAST_WORD)) begin
                st_nxt.rd_idx = '0;
            end else begin
                st_nxt.rd_idx = st_r.rd_idx + 4'h1;
            end
        end

        // Releasing chip select abandons a partial write or read sequence.
        if (cs_n_s) begin
            st_nxt.wr_cnt = adhp_pkg::WR_FIRST;
            st_nxt.rd_idx = '0;
        end

        // Byte mode presents each byte on the upper data lines.
        if (bus_width_s) begin
            rd_word = res[st_r.rd_idx[3:1]];
            st_nxt.dbo = '0;
            if (st_r.rd_idx[0] ^ byte_order_s) begin
                st_nxt.dbo[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W] =
                    rd_word[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W];
            end else begin
                st_nxt.dbo[adhp_pkg::BYTE_W +: adhp_pkg::BYTE_W] =
                    rd_word[adhp_pkg::BYTE_W-1:0];
            end
        end else begin
            rd_word = res[st_r.rd_idx[2:0]];
            st_nxt.dbo = rd_word;
        end

        // Serial frame: load on frame start, shift on the clock edges.
        if (fs_fall) begin
            st_nxt.in_frame = 1'b1;
            st_nxt.fall_cnt = '0;
            st_nxt.sh_b = '0;
            st_nxt.sh_c = '0;
            if (sel_s[adhp_pkg::SEL_C] && sel_s[adhp_pkg::SEL_B]) begin
                st_nxt.sh_a = {res[0], res[1], 64'h0};
                st_nxt.sh_b = {res[2], res[3], 16'h0};
                st_nxt.sh_c = {res[4], res[5]};
            end else if (sel_s[adhp_pkg::SEL_B]) begin
                st_nxt.sh_a = {res[0], res[1], res[4], 48'h0};
                st_nxt.sh_b = {res[2], res[3], res[5]};
            end else begin
                st_nxt.sh_a = {res[0], res[1], res[2], res[3], res[4], res[5]};
            end
        end else if (fs_rise) begin
            st_nxt.in_frame = 1'b0;
        end else if (st_r.in_frame) begin
            // The first bit is already out; shifting waits for one sample.
            if (sclk_rise && st_r.fall_cnt != '0) begin
                st_nxt.sh_a = {st_r.sh_a[adhp_pkg::SH_A_W-2:0], 1'b0};
                st_nxt.sh_b = {st_r.sh_b[adhp_pkg::SH_B_W-2:0], 1'b0};
                st_nxt.sh_c = {st_r.sh_c[adhp_pkg::SH_C_W-2:0], 1'b0};
            end
            if (sclk_fall) begin
                st_nxt.sdi_sh = sdi_word;
                if (st_r.fall_cnt != adhp_pkg::FALL_MAX) begin
                    st_nxt.fall_cnt = st_r.fall_cnt + 7'h1;
                end
            end
        end

        // Serial configuration commit, full or upper byte only.
        if (ser_upd) begin
            if (sdi_word[adhp_pkg::FULL_UPD_BIT]) begin
                st_nxt.cfg = sdi_word;
            end else begin
                st_nxt.cfg[adhp_pkg::UPPER_LSB +: adhp_pkg::BYTE_W] =
                    sdi_word[adhp_pkg::UPPER_LSB +: adhp_pkg::BYTE_W];
            end
        end

        // Hardware mode masks the groups that the pins own.
        if (cfg_src_s) begin
            st_nxt.eff = st_r.cfg;
        end else begin
            st_nxt.eff = st_r.cfg & adhp_pkg::HW_ACTIVE_MASK;
        end

        // Software mode without sequencing fans pair A start out to all pairs.
        if (cfg_src_s && !st_r.cfg[adhp_pkg::SEQ_BIT]) begin
            st_nxt.cvs = {3{cvs_s[0]}};
        end else begin
            st_nxt.cvs = cvs_s;
        end

        // Reference level in millivolts; the shift divides by 1024.
        ref_prod = (st_r.cfg[adhp_pkg::VREF_BIT] ? adhp_pkg::RANGE_HI_MV
                                                 : adhp_pkg::RANGE_LO_MV)
                   * (22'(st_r.cfg[adhp_pkg::DAC_LSB +: adhp_pkg::DAC_W]) + 22'h1);
        st_nxt.ref_mv = ref_prod[adhp_pkg::REF_SHIFT +: adhp_pkg::REF_MV_W];
    end

    // State register; the configuration resets to its documented value.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.cfg <= adhp_pkg::CFG_RESET;
            st_r.wr_n_d <= 1'b1;
            st_r.rd_n_d <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // The data bus drives only while a parallel read is in progress.
    assign db_oe = ~cs_n_s & ~rd_n_s & ~port_type_s & (&st_r.live);
    assign db_out = st_r.dbo;
    assign serial_out_first = st_r.sh_a[adhp_pkg::SH_A_W-1];
    assign serial_out_second = st_r.sh_b[adhp_pkg::SH_B_W-1];
    assign serial_out_third = st_r.sh_c[adhp_pkg::SH_C_W-1];
    assign convert_start_out = st_r.cvs;
    assign effective_config = st_r.eff;
    assign converter_configuration = st_r.cfg;
    assign reference_dac_code = st_r.cfg[adhp_pkg::DAC_LSB +: adhp_pkg::DAC_W];
    assign reference_output_mv = st_r.ref_mv;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_par_upper;
        wr_ev && st_r.wr_cnt == adhp_pkg::WR_FIRST
        |=> st_r.cfg[31:24] == $past(db_s[15:8]);
    endproperty
    a_par_upper: assert property (p_par_upper) else $error("Upper byte not written.");

    property p_word_second;
        wr_ev && !bus_width_s && st_r.wr_cnt == adhp_pkg::WR_SECOND
        |=> st_r.cfg[15:0] == $past(db_s) && st_r.cfg[23:16] == $past(st_r.pend[15:8]);
    endproperty
    a_word_second: assert property (p_word_second) else $error("Word write lost.");

    property p_hw_hold;
        !cfg_src_s |=> $stable(st_r.cfg);
    endproperty
    a_hw_hold: assert property (p_hw_hold) else $error("Register changed in hw mode.");

    property p_ref_full;
        resetn && st_r.cfg[9:0] == 10'h3ff ##1 st_r.cfg[9:0] == 10'h3ff
        |-> reference_output_mv == ($past(st_r.cfg[18]) ? 12'hbb8 : 12'h9c4);
    endproperty
    a_ref_full: assert property (p_ref_full) else $error("Reference level wrong.");

    property p_frame_load;
        fs_fall |=> serial_out_first == $past(res[0][15]);
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("Frame MSB wrong.");

    property p_shift;
        st_r.in_frame && !fs_rise && sclk_rise && st_r.fall_cnt != '0
        |=> serial_out_first == $past(st_r.sh_a[94]);
    endproperty
    a_shift: assert property (p_shift) else $error("Serial shift wrong.");

    property p_three_c;
        fs_fall && sel_s == 3'h7 |=> serial_out_third == $past(res[4][15]);
    endproperty
    a_three_c: assert property (p_three_c) else $error("Third port data wrong.");

    property p_sdi;
        st_r.in_frame && !fs_fall && !fs_rise && sclk_fall |=> st_r.sdi_sh[0] == $past(sdi_s);
    endproperty
    a_sdi: assert property (p_sdi) else $error("Serial input not captured.");

    property p_upper_only;
        ser_upd && !sdi_word[16] && !wr_ev
        |=> st_r.cfg[23:0] == $past(st_r.cfg[23:0]) && st_r.cfg[31:24] == $past(sdi_word[31:24]);
    endproperty
    a_upper_only: assert property (p_upper_only) else $error("Partial update wrong.");

    property p_convst;
        cfg_src_s && !st_r.cfg[23] |=> convert_start_out == {3{$past(cvs_s[0])}};
    endproperty
    a_convst: assert property (p_convst) else $error("Start fan-out wrong.");

    c_word_write: cover property (wr_ev && !bus_width_s && st_r.wr_cnt == adhp_pkg::WR_SECOND);
    c_ser_full: cover property (ser_upd && sdi_word[16]);
    c_three_ports: cover property (fs_fall && sel_s == 3'h7);
endmodule // adhp_host_port

// >>> tb/adhp_host_model.sv
// Host controller model: parallel strobes and serial frames at the host pins.
// Assumes one caller at a time, with reset already released.
`timescale 1ns/10ps
module adhp_host_model (
    input wire logic clk,
    input wire logic serial_out_first,
    input wire logic serial_out_second,
    input wire logic serial_out_third,
    input wire logic [15:0] db_out,
    input wire logic db_oe,
    output logic port_type_select,
    output logic chip_select_n,
    output logic write_n,
    output logic read_n,
    output logic [15:0] db_in,
    output logic frame_sync_in,
    output logic serial_clk,
    output logic serial_in
);
    // ************************************************************
    // Host pin drivers
    // ************************************************************
    // Idle levels; the serial clock stands still between frames.
    initial begin
        port_type_select = 1'h0;
        chip_select_n = 1'h1;
        write_n = 1'h1;
        read_n = 1'h1;
        db_in = 16'h0000;
        frame_sync_in = 1'h1;
        serial_clk = 1'h1;
        serial_in = 1'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Chip select stays low over a whole write sequence, so it is set apart.
    task automatic select(input logic ser, input logic cs_n);
        @(posedge clk);
        port_type_select <= ser;
        chip_select_n <= cs_n;
        wait_clk(4);
    endtask

    // Data is held past the rising strobe, then inverted so nothing stale lingers.
    task automatic par_write(input logic [15:0] d);
        @(posedge clk);
        db_in <= d;
        write_n <= 1'h0;
        wait_clk(4);
        write_n <= 1'h1;
        wait_clk(5);
        db_in <= ~d;
    endtask

    task automatic par_read(output logic [15:0] d, output logic oe);
        @(posedge clk);
        read_n <= 1'h0;
        wait_clk(6);
        d = db_oe ? db_out : ~db_out; // A released bus reads back inverted.
        oe = db_oe;
        read_n <= 1'h1;
        wait_clk(5);
    endtask

    // Every frame carries a register word on the serial input, MSB first.
    task automatic frame(input logic [31:0] w, input int nbits, output logic [95:0] a,
                         output logic [95:0] b, output logic [95:0] c);
        @(posedge clk);
        frame_sync_in <= 1'h0;
        serial_in <= w[31];
        wait_clk(8);
        for (int i = 0; i < nbits; i++) begin
            serial_clk <= 1'h0;
            a = {a[94:0], serial_out_first};
            b = {b[94:0], serial_out_second};
            c = {c[94:0], serial_out_third};
            wait_clk(4);
            serial_clk <= 1'h1;
            serial_in <= (i < 31) ? w[30-i] : ~serial_in;
            wait_clk(4);
        end
        frame_sync_in <= 1'h1;
        wait_clk(8);
    endtask
endmodule // adhp_host_model

// >>> tb/adhp_host_port_bench.sv
// Bench for the host port: reset and start checks, then serial frame rows, then hand-made cases.
// Assumes the host model drives host pins and this module the board pins.
`timescale 1ns/10ps
module adhp_host_port_bench;
    typedef struct packed {
        logic [2:0] en;
        logic [95:0] a;
        logic [95:0] b;
        logic [95:0] c;
    } adhp_row_t;
    logic clk = 1'h0;
    logic resetn, bus_width_select, byte_order_select, config_source_select;
    logic [2:0] port_enable, st;
    logic [15:0] res [6];
    logic port_type_select, chip_select_n, write_n, read_n, db_oe, oe;
    logic frame_sync_in, serial_clk, serial_in;
    logic serial_out_first, serial_out_second, serial_out_third;
    logic [15:0] db_in, db_out, d;
    logic [2:0] cso;
    logic [31:0] eff, cfg, exp_cfg;
    logic [9:0] dac;
    logic [11:0] mv;
    logic [95:0] a, b, c;
    adhp_row_t rows [5];
    int bad_count = 0;
    int checked = 0;

    // ************************************************************
    // Clock, instances and reporting
    // ************************************************************
    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;

    adhp_host_port dut (.clk, .resetn, .port_type_select, .bus_width_select,
        .byte_order_select, .config_source_select, .chip_select_n, .write_n, .read_n,
        .db_in, .db_out, .db_oe, .frame_sync_in, .serial_clk, .serial_in, .port_enable,
        .serial_out_first, .serial_out_second, .serial_out_third,
        .pair_a_convert_start(st[0]), .pair_b_convert_start(st[1]),
        .pair_c_convert_start(st[2]), .result_a0(res[0]), .result_a1(res[1]),
        .result_b0(res[2]), .result_b1(res[3]), .result_c0(res[4]), .result_c1(res[5]),
        .convert_start_out(cso), .effective_config(eff), .converter_configuration(cfg),
        .reference_dac_code(dac), .reference_output_mv(mv));

    adhp_host_model host (.clk, .serial_out_first, .serial_out_second,
        .serial_out_third, .db_out, .db_oe, .port_type_select, .chip_select_n,
        .write_n, .read_n, .db_in, .frame_sync_in, .serial_clk, .serial_in);

    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still ends in the report.
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        close_out;
    end

    // Main sequence; hardware mode first, so serial words must leave the register alone.
    initial begin
        {resetn, bus_width_select, byte_order_select, config_source_select, st} = 7'h0;
        port_enable = 3'h7;
        res = '{16'h8001, 16'h4002, 16'h2004, 16'h1008, 16'h0810, 16'h0420};
        rows[0] = '{3'h7, {res[0], res[1], 64'h0}, {res[2], res[3], 64'h0}, {res[4], res[5], 64'h0}};
        rows[1] = '{3'h3, {res[0], res[1], res[4], 48'h0}, {res[2], res[3], res[5], 48'h0}, 96'h0};
        rows[2] = '{3'h2, {res[0], res[1], res[4], 48'h0}, {res[2], res[3], res[5], 48'h0}, 96'h0};
        rows[3] = '{3'h1, {res[0], res[1], res[2], res[3], res[4], res[5]}, 96'h0, 96'h0};
        rows[4] = '{3'h4, {res[0], res[1], res[2], res[3], res[4], res[5]}, 96'h0, 96'h0};
        exp_cfg = adhp_pkg::CFG_RESET;
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        host.wait_clk(4);
        check("reset cfg", 96'(exp_cfg), 96'(cfg));
        check("reset mv", 96'(12'h9c4), 96'(mv));
        check("reset eff", 96'(32'h3ff), 96'(eff));
        st <= 3'h2;
        host.wait_clk(6);
        check("hw starts", 96'(3'h2), 96'(cso));
        st <= 3'h0;
        host.select(1'h1, 1'h1);
        for (int i = 0; i < 5; i++) begin
            port_enable <= rows[i].en;
            host.wait_clk(4);
            host.frame(32'hffffffff, 96, a, b, c);
            check("out first", rows[i].a, a);
            check("out second", rows[i].b, b);
            check("out third", rows[i].c, c);
            check("hw cfg kept", 96'(exp_cfg), 96'(cfg));
        end
        config_source_select <= 1'h1;
        host.frame(32'h000500cc, 32, a, b, c);
        host.wait_clk(6);
        check("full update", 96'(32'h000500cc), 96'(cfg));
        check("dac code", 96'(10'h0cc), 96'(dac));
        check("ref mv", 96'((3000 * 205) >> 10), 96'(mv));
        check("sw eff", 96'(32'h000500cc), 96'(eff));
        st <= 3'h1;
        host.wait_clk(6);
        check("sw starts", 96'(3'h7), 96'(cso));
        st <= 3'h0;
        host.frame(32'hc3fe_ff00, 32, a, b, c);
        host.wait_clk(6);
        check("upper update", 96'(32'hc30500cc), 96'(cfg));
        host.select(1'h0, 1'h0);
        host.par_write(16'h1234);
        check("first word", 96'(32'h120500cc), 96'(cfg));
        host.par_write(16'h4678);
        check("second word", 96'(32'h12344678), 96'(cfg));
        host.select(1'h0, 1'h1);
        bus_width_select <= 1'h1;
        host.select(1'h0, 1'h0);
        host.par_write(16'h9a55);
        host.par_write(16'hb455);
        check("byte upper", 96'(32'h9a344678), 96'(cfg));
        host.par_write(16'hce55);
        host.par_write(16'hf055);
        check("byte update", 96'(32'h9ab4cef0), 96'(cfg));
        host.select(1'h0, 1'h1);
        exp_cfg = 32'h9ab4cef0;
        config_source_select <= 1'h0;
        host.wait_clk(4);
        check("hw mask", 96'(exp_cfg & adhp_pkg::HW_ACTIVE_MASK), 96'(eff));
        bus_width_select <= 1'h0;
        host.select(1'h0, 1'h0);
        host.par_write(16'hffff);
        check("hw write", 96'(exp_cfg), 96'(cfg));
        res <= '{16'h7e01, 16'h6d02, 16'h5c03, 16'h4b04, 16'h3a05, 16'h2906};
        for (int i = 0; i < 6; i++) begin
            host.par_read(d, oe);
            check("word read", 96'(res[i]), 96'(d));
            check("read enable", 96'(1'h1), 96'(oe));
        end
        for (int o = 0; o < 2; o++) begin
            host.select(1'h0, 1'h1);
            bus_width_select <= 1'h1;
            byte_order_select <= o[0];
            host.select(1'h0, 1'h0);
            host.par_read(d, oe);
            check("byte first", 96'({o ? res[0][15:8] : res[0][7:0], 8'h00}), 96'(d));
            host.par_read(d, oe);
            check("byte next", 96'({o ? res[0][7:0] : res[0][15:8], 8'h00}), 96'(d));
        end
        // Reset in mid-run with chip select low must not step the read index.
        resetn <= 1'h0;
        host.wait_clk(2);
        resetn <= 1'h1;
        bus_width_select <= 1'h0;
        host.wait_clk(4);
        check("rst cfg", 96'(adhp_pkg::CFG_RESET), 96'(cfg));
        host.par_read(d, oe);
        check("rst read", 96'(res[0]), 96'(d));
        host.select(1'h1, 1'h0);
        host.par_read(d, oe);
        check("serial no drive", 96'(1'h0), 96'(oe));
        close_out;
    end
endmodule // adhp_host_port_bench
